// File: digitizer_config_regs_15_28.sv
module digitizer_config_regs_15_28
    import digitizer_cfg_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic WR_STB_I, // one-cycle write strobe from serial port
    input wire logic RD_STB_I, // one-cycle read strobe
    input wire logic [7:0] ADDR_I, // register subaddress
    input wire logic [7:0] WDATA_I,
    output logic [7:0] RDATA_O, // registered read data
    output logic RVALID_O, // pulse with read data
    input wire logic [7:0] FINE_OFS_R_HI_I, // upper fine offset bits from 0Dh
    input wire logic [7:0] FINE_OFS_G_HI_I, // from 0Ch
    input wire logic [7:0] FINE_OFS_B_HI_I, // from 0Bh
    input wire logic CLK5_I, // internal 5 MHz clock, async
    input wire logic COAST_I, // coast level, async
    input wire logic CLAMP_I, // clamp level, async
    input wire logic LINE_UPD_I, // one-cycle line update from datapath
    input wire logic signed [15:0] BLANK_ERR_I, // summed blank-level error
    output logic TEST_PIN_O, // test pin data
    output logic TEST_PIN_OE_O, // test pin enable, high drives
    output cfg_t CFG_O, // decoded configuration
    output logic [9:0] FINE_OFS_R_O,
    output logic [9:0] FINE_OFS_G_O,
    output logic [9:0] FINE_OFS_B_O,
    output logic signed [15:0] LVL_CORR_O // accumulated offset correction
);
    // register storage
    logic [7:0] out_fmt_r; // clamp edge, chroma order, subsampling
    logic [7:0] test_r; // tolerance, test source, pll controls
    logic [7:0] in_sel_r; // four input selectors, kept raw
    logic [7:0] sync_sel_r; // sync sources; must-one bit dropped
    logic [7:0] bg_gain_r; // green and blue gain codes
    logic [7:0] r_gain_r; // red gain code
    logic [7:0] fine_lsb_r; // low fine offset bits, three channels
    logic [7:0] b_ofs_r; // blue coarse offset
    logic [7:0] g_ofs_r; // green coarse offset
    logic [7:0] r_ofs_r; // red coarse offset
    logic [7:0] hs_start_r; // hsync output start pixel
    logic [7:0] misc_r; // copy protect and vertical alignment
    logic [7:0] lvl_en_r; // level control enable
    logic [7:0] lvl_filt_r; // level control filter coefficients
    logic [7:0] rdata_nxt; // read mux result
    logic [2:0] tst_s1_r, tst_s2_r; // test source synchronisers
    logic test_pin_nxt;
    logic signed [15:0] corr_r; // level correction accumulator
    logic signed [15:0] avg_err; // per-line averaged error
    logic signed [15:0] step;

    // write path; reserved bits masked so they never store
    always_ff @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            out_fmt_r <= 8'h00;
            test_r <= 8'h00;
            in_sel_r <= 8'h00;
            sync_sel_r <= 8'h00;
            bg_gain_r <= RST_BG_GAIN;
            r_gain_r <= RST_R_GAIN;
            fine_lsb_r <= 8'h00;
            b_ofs_r <= {2'h0, RST_COARSE_OFS};
            g_ofs_r <= {2'h0, RST_COARSE_OFS};
            r_ofs_r <= {2'h0, RST_COARSE_OFS};
            hs_start_r <= RST_HS_START;
            misc_r <= 8'h00;
            lvl_en_r <= 8'h00;
            lvl_filt_r <= 8'h00;
        end else if (WR_STB_I) begin
            case (ADDR_I)
                OFS_OUT_FMT: out_fmt_r <= WDATA_I & MSK_OUT_FMT;
                OFS_TEST_PLL: test_r <= WDATA_I & MSK_TEST_PLL;
                OFS_IN_SEL: in_sel_r <= WDATA_I;
                // bit 7 is a must-write-one from the host; not stored
                OFS_SYNC_SEL: sync_sel_r <= WDATA_I & MSK_SYNC_SEL;
                OFS_BG_GAIN: bg_gain_r <= WDATA_I;
                OFS_R_GAIN: r_gain_r <= WDATA_I & MSK_R_GAIN;
                OFS_FINE_LSB: fine_lsb_r <= WDATA_I & MSK_FINE_LSB;
                OFS_B_OFS: b_ofs_r <= WDATA_I & MSK_OFS;
                OFS_G_OFS: g_ofs_r <= WDATA_I & MSK_OFS;
                OFS_R_OFS: r_ofs_r <= WDATA_I & MSK_OFS;
                OFS_HS_START: hs_start_r <= WDATA_I;
                OFS_MISC: misc_r <= WDATA_I & MSK_MISC;
                OFS_LVL_EN: lvl_en_r <= WDATA_I & MSK_LVL_EN;
                OFS_LVL_FILT: lvl_filt_r <= WDATA_I & MSK_LVL_FILT;
                default: ; // other subaddresses belong elsewhere
            endcase
        end
    end

    // read mux; unmapped returns zero
    always_comb begin
        case (ADDR_I)
            OFS_OUT_FMT: rdata_nxt = out_fmt_r;
            OFS_TEST_PLL: rdata_nxt = test_r;
            OFS_IN_SEL: rdata_nxt = in_sel_r;
            OFS_SYNC_SEL: rdata_nxt = sync_sel_r;
            OFS_BG_GAIN: rdata_nxt = bg_gain_r;
            OFS_R_GAIN: rdata_nxt = r_gain_r;
            OFS_FINE_LSB: rdata_nxt = fine_lsb_r;
            OFS_B_OFS: rdata_nxt = b_ofs_r;
            OFS_G_OFS: rdata_nxt = g_ofs_r;
            OFS_R_OFS: rdata_nxt = r_ofs_r;
            OFS_HS_START: rdata_nxt = hs_start_r;
            OFS_MISC: rdata_nxt = misc_r;
            OFS_LVL_EN: rdata_nxt = lvl_en_r;
            OFS_LVL_FILT: rdata_nxt = lvl_filt_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            RDATA_O <= 8'h00;
            RVALID_O <= 1'b0;
        end else begin
            RVALID_O <= RD_STB_I;
            if (RD_STB_I) begin
                RDATA_O <= rdata_nxt;
            end
        end
    end

    // configuration decode
    always_comb begin
        CFG_O.clamp_leading = out_fmt_r[BIT_CLAMP_REF];
        CFG_O.fmt_422 = out_fmt_r[BIT_SUBSAMPLE];
        // order bit ignored in 4:4:4 output
        CFG_O.chroma_cb_first = out_fmt_r[BIT_SUBSAMPLE] & out_fmt_r[BIT_CHROMA_ORDER];
        CFG_O.pix_tol = test_r[7:5];
        CFG_O.test_src = test_r[3:2];
        CFG_O.pll_power_off = test_r[BIT_PLL_OFF];
        CFG_O.pll_startup_enable = test_r[BIT_PLL_START];
        // reserved code 11 decodes to channel one; green 11 is channel four
        CFG_O.sog_sel = (in_sel_r[7:6] == 2'h3) ? 2'h0 : in_sel_r[7:6];
        CFG_O.red_sel = (in_sel_r[5:4] == 2'h3) ? 2'h0 : in_sel_r[5:4];
        CFG_O.green_sel = {1'b0, in_sel_r[3:2]};
        CFG_O.blue_sel = (in_sel_r[1:0] == 2'h3) ? 2'h0 : in_sel_r[1:0];
        CFG_O.vsync_src_b = sync_sel_r[BIT_VSRC];
        CFG_O.hsync_src_b = sync_sel_r[BIT_HSRC];
        // gain = 0.5 + 0.1*code, passed as the code
        CFG_O.gain_g = bg_gain_r[7:4];
        CFG_O.gain_b = bg_gain_r[3:0];
        CFG_O.gain_r = r_gain_r[3:0];
        CFG_O.cofs_b = b_ofs_r[5:0];
        CFG_O.cofs_g = g_ofs_r[5:0];
        CFG_O.cofs_r = r_ofs_r[5:0];
        CFG_O.fofs_lsb_r = fine_lsb_r[5:4];
        CFG_O.fofs_lsb_g = fine_lsb_r[3:2];
        CFG_O.fofs_lsb_b = fine_lsb_r[1:0];
        CFG_O.hsync_output_start = hs_start_r;
        CFG_O.copy_protect_compat_enable = misc_r[BIT_COPY_COMPAT];
        CFG_O.vertical_output_alignment = misc_r[BIT_VALIGN];
        CFG_O.auto_level_control = lvl_en_r[BIT_LVL_EN];
        CFG_O.level_vertical_coeff = lvl_filt_r[6:3];
        CFG_O.level_horizontal_coeff = lvl_filt_r[2:0];
    end

    // ten-bit fine offsets: high byte elsewhere, low bits here
    always_comb begin
        FINE_OFS_R_O = {FINE_OFS_R_HI_I, fine_lsb_r[5:4]};
        FINE_OFS_G_O = {FINE_OFS_G_HI_I, fine_lsb_r[3:2]};
        FINE_OFS_B_O = {FINE_OFS_B_HI_I, fine_lsb_r[1:0]};
    end

    // two-stage sync of async test sources; first stage read only by second
    always_ff @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            tst_s1_r <= 3'h0;
            tst_s2_r <= 3'h0;
        end else begin
            tst_s1_r <= {CLAMP_I, COAST_I, CLK5_I};
            tst_s2_r <= tst_s1_r;
        end
    end

    // test pin source mux
    always_comb begin
        case (test_r[3:2])
            TST_CLK5: test_pin_nxt = tst_s2_r[0];
            TST_COAST: test_pin_nxt = tst_s2_r[1];
            TST_CLAMP: test_pin_nxt = tst_s2_r[2];
            default: test_pin_nxt = 1'b0;
        endcase
    end

    // pin data from flop; enable drops for hi-z code
    always_ff @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            TEST_PIN_O <= 1'b0;
        end else begin
            TEST_PIN_O <= test_pin_nxt;
        end
    end
    assign TEST_PIN_OE_O = (test_r[3:2] != TST_HIZ);

    // average over 2^nsh samples is a right shift of the summed error
    assign avg_err = BLANK_ERR_I >>> lvl_filt_r[2:0];
    // fraction 2^-nsv of the error per update; shift limits precision
    assign step = avg_err >>> lvl_filt_r[6:3];

    // accumulate correction immediately on each line update
    always_ff @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            corr_r <= 16'sh0000;
        end else if (!lvl_en_r[BIT_LVL_EN]) begin
            corr_r <= 16'sh0000; // disabled: no correction held
        end else if (LINE_UPD_I) begin
            corr_r <= corr_r - step;
        end
    end
    assign LVL_CORR_O = corr_r;

    // checks
    a_rd_reserved_zero: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        RD_STB_I && ADDR_I == OFS_MISC |=> (RDATA_O & ~MSK_MISC) == 8'h00)
        else $error("misc reserved bits nonzero");
    a_wr_readback: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        WR_STB_I && ADDR_I == OFS_HS_START ##1 RD_STB_I && ADDR_I == OFS_HS_START
        |=> RDATA_O == $past(WDATA_I, 2))
        else $error("hsync start readback mismatch");
    a_chroma_gate: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        !CFG_O.fmt_422 |-> !CFG_O.chroma_cb_first)
        else $error("chroma order active in 4:4:4");
    a_green_ch4: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        WR_STB_I && ADDR_I == OFS_IN_SEL && WDATA_I[3:2] == 2'h3
        |=> CFG_O.green_sel == 3'h3 && CFG_O.red_sel != 2'h3)
        else $error("input select decode wrong");
    a_hiz_oe: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        WR_STB_I && ADDR_I == OFS_TEST_PLL |=> TEST_PIN_OE_O == ($past(WDATA_I[3:2]) != TST_HIZ))
        else $error("test pin enable wrong");
    a_pll_bits: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        WR_STB_I && ADDR_I == OFS_TEST_PLL
        |=> CFG_O.pll_power_off == $past(WDATA_I[1]) && CFG_O.pll_startup_enable == $past(WDATA_I[0]))
        else $error("pll control bits wrong");
    a_lvl_off_zero: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        !CFG_O.auto_level_control |=> LVL_CORR_O == 16'sh0000)
        else $error("correction held while disabled");
    a_lvl_step: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        CFG_O.auto_level_control && LINE_UPD_I && lvl_filt_r == 8'h00
        |=> LVL_CORR_O == $past(LVL_CORR_O) - $past(BLANK_ERR_I))
        else $error("full-strength correction wrong");
    a_fine_concat: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        FINE_OFS_G_O[9:2] == FINE_OFS_G_HI_I && FINE_OFS_G_O[1:0] == CFG_O.fofs_lsb_g)
        else $error("fine offset assembly wrong");

    // the checks below share one clock and one reset
    default clocking dflt_cb @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);

    // each field checked below shows its write in the decoded view one cycle later
    a_clamp_ref: assert property (WR_STB_I && ADDR_I == OFS_OUT_FMT
        |=> CFG_O.clamp_leading == $past(WDATA_I[BIT_CLAMP_REF]))
        else $error("clamp reference wrong");

    a_fmt_select: assert property (WR_STB_I && ADDR_I == OFS_OUT_FMT
        |=> CFG_O.fmt_422 == $past(WDATA_I[BIT_SUBSAMPLE]))
        else $error("subsampling select wrong");

    a_chroma_order: assert property (WR_STB_I && ADDR_I == OFS_OUT_FMT && WDATA_I[1]
        |=> CFG_O.chroma_cb_first == $past(WDATA_I[BIT_CHROMA_ORDER]))
        else $error("chroma order wrong");

    a_pix_tol: assert property (WR_STB_I && ADDR_I == OFS_TEST_PLL
        |=> CFG_O.pix_tol == $past(WDATA_I[7:5]))
        else $error("pixel tolerance wrong");

    a_pll_start: assert property (WR_STB_I && ADDR_I == OFS_TEST_PLL
        |=> CFG_O.pll_startup_enable == $past(WDATA_I[BIT_PLL_START]))
        else $error("pll startup bit wrong");

    // legal selector codes pass straight through
    a_sog_select: assert property (WR_STB_I && ADDR_I == OFS_IN_SEL && WDATA_I[7:6] != 2'h3
        |=> CFG_O.sog_sel == $past(WDATA_I[7:6]))
        else $error("sync on green select wrong");

    a_blue_select: assert property (WR_STB_I && ADDR_I == OFS_IN_SEL && WDATA_I[1:0] != 2'h3
        |=> CFG_O.blue_sel == $past(WDATA_I[1:0]))
        else $error("blue select wrong");

    a_sync_src: assert property (WR_STB_I && ADDR_I == OFS_SYNC_SEL
        |=> {CFG_O.vsync_src_b, CFG_O.hsync_src_b} == $past({WDATA_I[2], WDATA_I[0]}))
        else $error("sync source select wrong");

    a_gain_gb: assert property (WR_STB_I && ADDR_I == OFS_BG_GAIN
        |=> {CFG_O.gain_g, CFG_O.gain_b} == $past(WDATA_I))
        else $error("green blue gain wrong");

    a_gain_red: assert property (WR_STB_I && ADDR_I == OFS_R_GAIN
        |=> CFG_O.gain_r == $past(WDATA_I[3:0]))
        else $error("red gain wrong");

    a_fine_lsb: assert property (WR_STB_I && ADDR_I == OFS_FINE_LSB
        |=> {CFG_O.fofs_lsb_r, CFG_O.fofs_lsb_g, CFG_O.fofs_lsb_b} == $past(WDATA_I[5:0]))
        else $error("fine offset low bits wrong");

    a_coarse_blue: assert property (WR_STB_I && ADDR_I == OFS_B_OFS
        |=> CFG_O.cofs_b == $past(WDATA_I[5:0]))
        else $error("blue coarse offset wrong");

    a_coarse_red: assert property (WR_STB_I && ADDR_I == OFS_R_OFS
        |=> CFG_O.cofs_r == $past(WDATA_I[5:0]))
        else $error("red coarse offset wrong");

    a_hs_start: assert property (WR_STB_I && ADDR_I == OFS_HS_START
        |=> CFG_O.hsync_output_start == $past(WDATA_I))
        else $error("hsync start wrong");

    a_copy_compat: assert property (WR_STB_I && ADDR_I == OFS_MISC
        |=> CFG_O.copy_protect_compat_enable == $past(WDATA_I[BIT_COPY_COMPAT]))
        else $error("copy protect bit wrong");

    a_vert_align: assert property (WR_STB_I && ADDR_I == OFS_MISC
        |=> CFG_O.vertical_output_alignment == $past(WDATA_I[BIT_VALIGN]))
        else $error("vertical alignment bit wrong");

    a_level_enable: assert property (WR_STB_I && ADDR_I == OFS_LVL_EN
        |=> CFG_O.auto_level_control == $past(WDATA_I[BIT_LVL_EN]))
        else $error("level enable wrong");

    a_filter_fields: assert property (WR_STB_I && ADDR_I == OFS_LVL_FILT
        |=> {CFG_O.level_vertical_coeff, CFG_O.level_horizontal_coeff} == $past(WDATA_I[6:0]))
        else $error("filter fields wrong");

    // weakest vertical code: only the top bit of the error survives
    a_vcoeff_min: assert property (CFG_O.auto_level_control && LINE_UPD_I
        && CFG_O.level_vertical_coeff == 4'hF |=> LVL_CORR_O == $past(LVL_CORR_O)
        - (($past(BLANK_ERR_I) >>> $past(CFG_O.level_horizontal_coeff)) >>> 15))
        else $error("weakest correction wrong");

    // hi-z code must not leave stale data on the pin
    a_test_data_hiz: assert property (CFG_O.test_src == TST_HIZ
        |=> !TEST_PIN_O)
        else $error("test pin data in hi-z");

    a_rvalid_pulse: assert property (RD_STB_I
        |=> RVALID_O)
        else $error("read answer missing");

    a_unmapped_read: assert property (RD_STB_I && ADDR_I == 8'h17
        |=> RDATA_O == 8'h00)
        else $error("unmapped read nonzero");

    c_green_ch4: cover property (CFG_O.green_sel == 3'h3);
    c_unmapped_read: cover property (RD_STB_I && ADDR_I == 8'h17);
    c_write_422: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        WR_STB_I && ADDR_I == OFS_OUT_FMT && WDATA_I[BIT_SUBSAMPLE]);
    c_lvl_update: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        CFG_O.auto_level_control && LINE_UPD_I);
    c_test_hiz: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I) !TEST_PIN_OE_O);
endmodule : digitizer_config_regs_15_28

// File: digitizer_cfg_pkg.sv
package digitizer_cfg_pkg;
    // register indices as printed (byte-wide registers on the serial port)
    localparam logic [7:0] OFS_OUT_FMT = 8'h15;
    localparam logic [7:0] OFS_TEST_PLL = 8'h16;
    localparam logic [7:0] OFS_IN_SEL = 8'h19;
    localparam logic [7:0] OFS_SYNC_SEL = 8'h1A;
    localparam logic [7:0] OFS_BG_GAIN = 8'h1B;
    localparam logic [7:0] OFS_R_GAIN = 8'h1C;
    localparam logic [7:0] OFS_FINE_LSB = 8'h1D;
    localparam logic [7:0] OFS_B_OFS = 8'h1E;
    localparam logic [7:0] OFS_G_OFS = 8'h1F;
    localparam logic [7:0] OFS_R_OFS = 8'h20;
    localparam logic [7:0] OFS_HS_START = 8'h21;
    localparam logic [7:0] OFS_MISC = 8'h22;
    localparam logic [7:0] OFS_LVL_EN = 8'h26;
    localparam logic [7:0] OFS_LVL_FILT = 8'h28;
    // reset values
    localparam logic [7:0] RST_BG_GAIN = 8'h55;
    localparam logic [7:0] RST_R_GAIN = 8'h05;
    localparam logic [5:0] RST_COARSE_OFS = 6'h20;
    localparam logic [7:0] RST_HS_START = 8'h09;
    // writable-bit masks (reserved bits clear)
    localparam logic [7:0] MSK_OUT_FMT = 8'h0E;
    localparam logic [7:0] MSK_TEST_PLL = 8'hEF;
    localparam logic [7:0] MSK_SYNC_SEL = 8'h05;
    localparam logic [7:0] MSK_R_GAIN = 8'h0F;
    localparam logic [7:0] MSK_FINE_LSB = 8'h3F;
    localparam logic [7:0] MSK_OFS = 8'h3F;
    localparam logic [7:0] MSK_MISC = 8'h0A;
    localparam logic [7:0] MSK_LVL_EN = 8'h80;
    localparam logic [7:0] MSK_LVL_FILT = 8'h7F;
    // field positions
    localparam int BIT_CLAMP_REF = 3;
    localparam int BIT_CHROMA_ORDER = 2;
    localparam int BIT_SUBSAMPLE = 1;
    localparam int BIT_PLL_OFF = 1;
    localparam int BIT_PLL_START = 0;
    localparam int BIT_VSRC = 2;
    localparam int BIT_HSRC = 0;
    localparam int BIT_COPY_COMPAT = 3;
    localparam int BIT_VALIGN = 1;
    localparam int BIT_LVL_EN = 7;
    // test pin source codes
    localparam logic [1:0] TST_CLK5 = 2'h0;
    localparam logic [1:0] TST_COAST = 2'h1;
    localparam logic [1:0] TST_CLAMP = 2'h2;
    localparam logic [1:0] TST_HIZ = 2'h3;
    // decoded configuration to the datapath
    typedef struct packed {
        logic clamp_leading;
        logic fmt_422;
        logic chroma_cb_first;
        logic [2:0] pix_tol;
        logic [1:0] test_src;
        logic pll_power_off;
        logic pll_startup_enable;
        logic [1:0] sog_sel;
        logic [1:0] red_sel;
        logic [2:0] green_sel;
        logic [1:0] blue_sel;
        logic vsync_src_b;
        logic hsync_src_b;
        logic [3:0] gain_r;
        logic [3:0] gain_g;
        logic [3:0] gain_b;
        logic [5:0] cofs_r;
        logic [5:0] cofs_g;
        logic [5:0] cofs_b;
        logic [1:0] fofs_lsb_r;
        logic [1:0] fofs_lsb_g;
        logic [1:0] fofs_lsb_b;
        logic [7:0] hsync_output_start;
        logic copy_protect_compat_enable;
        logic vertical_output_alignment;
        logic auto_level_control;
        logic [3:0] level_vertical_coeff;
        logic [2:0] level_horizontal_coeff;
    } cfg_t;
endpackage : digitizer_cfg_pkg

// File: digitizer_host_model.sv
// host side of the register port, bytes only, strobes launched on falling edges
module digitizer_host_model
    import digitizer_cfg_pkg::*;
(
    input wire logic clk_i,
    output logic wr_stb_o,
    output logic rd_stb_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        wr_stb_o = 1'b0;
        rd_stb_o = 1'b0;
        addr_o = 8'hA5;
        wdata_o = 8'h5A;
    end
    // one byte write; strobe spans exactly one rising edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = (a == OFS_SYNC_SEL) ? (d | 8'h80) : d;
        wr_stb_o = 1'b1;
        @(negedge clk_i);
        wr_stb_o = 1'b0;
        // released lines toggle so stale values cannot pass
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask : wr_reg
    // one byte read; answer pulse lands on the taking edge and is sampled at the next falling edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_i);
        addr_o = a;
        rd_stb_o = 1'b1;
        @(negedge clk_i);
        // answer pulse stands only in the cycle after the taking edge
        ok = rvalid_i;
        d = rdata_i;
        rd_stb_o = 1'b0;
        addr_o = ~addr_o;
    endtask : rd_reg
endmodule : digitizer_host_model

// File: tb_digitizer_config_regs_15_28.sv
module tb_digitizer_config_regs_15_28
    import digitizer_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, wr, rd, clk5, coast, clamp, upd, rvalid, tpin, toe, ok;
    logic [7:0] addr, wdata, rdata, fr, fg, fb, d, f;
    logic signed [15:0] err, corr, exp_corr;
    logic [9:0] fine_r, fine_g, fine_b;
    cfg_t cfg;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [7:0] sh [256]; // shadow of every register, as expected
    logic [7:0] regs [14] = '{OFS_OUT_FMT, OFS_TEST_PLL, OFS_IN_SEL, OFS_SYNC_SEL, OFS_BG_GAIN,
        OFS_R_GAIN, OFS_FINE_LSB, OFS_B_OFS, OFS_G_OFS, OFS_R_OFS, OFS_HS_START, OFS_MISC,
        OFS_LVL_EN, OFS_LVL_FILT};
    digitizer_config_regs_15_28 i_dut (.REF_CLK_I(clk), .NRST_I(nrst), .WR_STB_I(wr),
        .RD_STB_I(rd), .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .RVALID_O(rvalid),
        .FINE_OFS_R_HI_I(fr), .FINE_OFS_G_HI_I(fg), .FINE_OFS_B_HI_I(fb), .CLK5_I(clk5),
        .COAST_I(coast), .CLAMP_I(clamp), .LINE_UPD_I(upd), .BLANK_ERR_I(err),
        .TEST_PIN_O(tpin), .TEST_PIN_OE_O(toe), .CFG_O(cfg), .FINE_OFS_R_O(fine_r),
        .FINE_OFS_G_O(fine_g), .FINE_OFS_B_O(fine_b), .LVL_CORR_O(corr));
    digitizer_host_model i_host (.clk_i(clk), .wr_stb_o(wr), .rd_stb_o(rd), .addr_o(addr),
        .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard, far above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // writable bits per register; reserved and unmapped read as zero
    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            OFS_OUT_FMT: return MSK_OUT_FMT;
            OFS_TEST_PLL: return MSK_TEST_PLL;
            OFS_IN_SEL, OFS_BG_GAIN, OFS_HS_START: return 8'hFF;
            OFS_SYNC_SEL: return MSK_SYNC_SEL;
            OFS_R_GAIN: return MSK_R_GAIN;
            OFS_FINE_LSB: return MSK_FINE_LSB;
            OFS_B_OFS, OFS_G_OFS, OFS_R_OFS: return MSK_OFS;
            OFS_MISC: return MSK_MISC;
            OFS_LVL_EN: return MSK_LVL_EN;
            OFS_LVL_FILT: return MSK_LVL_FILT;
            default: return 8'h00;
        endcase
    endfunction : msk
    function automatic logic [7:0] rstv(input logic [7:0] a);
        case (a)
            OFS_BG_GAIN: return RST_BG_GAIN;
            OFS_R_GAIN: return RST_R_GAIN;
            OFS_B_OFS, OFS_G_OFS, OFS_R_OFS: return {2'b00, RST_COARSE_OFS};
            OFS_HS_START: return RST_HS_START;
            default: return 8'h00;
        endcase
    endfunction : rstv
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd_reg(a, d, ok);
        check(ok, 1'b1);
        check(d, exp);
    endtask : rd_chk
    // reset held 20 cycles, then every register read back against its default
    task automatic do_reset();
        nrst = 1'b0;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        foreach (regs[i]) sh[regs[i]] = rstv(regs[i]);
        check({toe, corr}, 17'h10000);
        foreach (regs[i]) rd_chk(regs[i], sh[regs[i]]);
    endtask : do_reset
    // decoded outputs against the shadow
    task automatic cfg_chk();
        check(cfg.clamp_leading, sh[OFS_OUT_FMT][3]);
        check(cfg.fmt_422, sh[OFS_OUT_FMT][1]);
        if (sh[OFS_OUT_FMT][1]) check(cfg.chroma_cb_first, sh[OFS_OUT_FMT][2]);
        else check(cfg.chroma_cb_first, 1'b0);
        check(cfg.pix_tol, sh[OFS_TEST_PLL][7:5]);
        check(cfg.test_src, sh[OFS_TEST_PLL][3:2]);
        check({cfg.pll_power_off, cfg.pll_startup_enable}, sh[OFS_TEST_PLL][1:0]);
        check(cfg.green_sel, {1'b0, sh[OFS_IN_SEL][3:2]});
        check(cfg.red_sel, (sh[OFS_IN_SEL][5:4] == 2'h3) ? 2'h0 : sh[OFS_IN_SEL][5:4]);
        check(cfg.sog_sel, (sh[OFS_IN_SEL][7:6] == 2'h3) ? 2'h0 : sh[OFS_IN_SEL][7:6]);
        check(cfg.blue_sel, (sh[OFS_IN_SEL][1:0] == 2'h3) ? 2'h0 : sh[OFS_IN_SEL][1:0]);
        check({cfg.vsync_src_b, cfg.hsync_src_b}, {sh[OFS_SYNC_SEL][2], sh[OFS_SYNC_SEL][0]});
        check({cfg.gain_g, cfg.gain_b, cfg.gain_r}, {sh[OFS_BG_GAIN], sh[OFS_R_GAIN][3:0]});
        check({fine_r, fine_g, fine_b}, {fr, sh[OFS_FINE_LSB][5:4], fg, sh[OFS_FINE_LSB][3:2],
            fb, sh[OFS_FINE_LSB][1:0]});
        check({cfg.cofs_r, cfg.cofs_g, cfg.cofs_b}, {sh[OFS_R_OFS][5:0], sh[OFS_G_OFS][5:0],
            sh[OFS_B_OFS][5:0]});
        check(cfg.hsync_output_start, sh[OFS_HS_START]);
        check({cfg.copy_protect_compat_enable, cfg.vertical_output_alignment},
            {sh[OFS_MISC][3], sh[OFS_MISC][1]});
        check(cfg.auto_level_control, sh[OFS_LVL_EN][7]);
        check({cfg.level_vertical_coeff, cfg.level_horizontal_coeff}, sh[OFS_LVL_FILT][6:0]);
    endtask : cfg_chk
    initial begin
        void'($urandom(32'h9430197b));
        {nrst, clk5, coast, clamp, upd, err, fr, fg, fb} = '0;
        do_reset();
        // random fills, first all ones then all zeros as corners
        for (int r = 0; r < 24; r++) begin
            {fr, fg, fb} = 24'($urandom);
            foreach (regs[i]) begin
                d = (r == 0) ? 8'hFF : (r == 1) ? 8'h00 : 8'($urandom);
                i_host.wr_reg(regs[i], d);
                sh[regs[i]] = d & msk(regs[i]);
            end
            i_host.wr_reg(8'h17, 8'hFF);
            rd_chk(8'h17, 8'h00);
            rd_chk(8'h29, 8'h00);
            foreach (regs[i]) rd_chk(regs[i], sh[regs[i]]);
            cfg_chk();
        end
        // test pin source per code, synchronizer delay covered by the wait
        for (int c = 0; c < 4; c++) begin
            {clk5, coast, clamp} = 3'($urandom);
            i_host.wr_reg(OFS_TEST_PLL, {4'h0, 2'(c), 2'b00});
            repeat (4) @(negedge clk);
            check(toe, c != 3);
            check(tpin, (c == 0) ? clk5 : (c == 1) ? coast : (c == 2) ? clamp : 1'b0);
        end
        // level control, back-to-back updates at extreme and random filter codes
        i_host.wr_reg(OFS_LVL_EN, 8'h80);
        exp_corr = '0;
        for (int k = 0; k < 6; k++) begin
            f = (k == 0) ? 8'h00 : (k == 1) ? 8'h7F : 8'($urandom) & 8'h7F;
            i_host.wr_reg(OFS_LVL_FILT, f);
            repeat (3) begin
                err = 16'($urandom);
                upd = 1'b1;
                @(negedge clk);
                exp_corr = exp_corr - ((err >>> f[2:0]) >>> f[6:3]);
                check(corr, exp_corr);
            end
            upd = 1'b0;
        end
        // disabled: accumulator cleared and updates ignored
        i_host.wr_reg(OFS_LVL_EN, 8'h00);
        upd = 1'b1;
        err = 16'h1234;
        @(negedge clk);
        upd = 1'b0;
        @(negedge clk);
        check(corr, 16'h0000);
        do_reset();
        report_and_stop();
    end
endmodule : tb_digitizer_config_regs_15_28
